// ---- logic/cii_regs.svh ----
// register offsets, field positions and reset values of the core interrupt interface
`ifndef CII_REGS_SVH
`define CII_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CII_OFS_CTRL      8'h00
`define CII_OFS_CAUSE     8'h04
`define CII_OFS_PEND      8'h08
`define CII_OFS_ISTAT     8'h0C
`define CII_OFS_IMASK     8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CII_CTRL_MODE_BIT  0
`define CII_CTRL_EN_LSB    8
`define CII_REQUESTED_PRIO_FIELD_LSB 0
`define CII_PRIO_LEVEL_FIELD_LSB  8
`define CII_CAUSE_SEL_LSB  16
`define CII_PEND_VEC_LSB   8
`define CII_PEND_ANY_BIT   16
`define CII_EV_TAKEN_BIT   0
`define CII_EV_TIMER_BIT   1
// ----------------------------------------------------------------
// reset values and merge selector base
// ----------------------------------------------------------------
`define CII_CTRL_RST      32'h0000_3F00
`define CII_IMASK_RST     2'h0
`define CII_SEL_BASE      3'h2
`endif

// ---- logic/cii_pkg.sv ----
// types shared by the core interrupt interface
`default_nettype none
package cii_pkg;
   // interrupt mode of the request inputs
   typedef enum logic [0:0] {
      CII_MODE_VECTORED = 1'b0,
      CII_MODE_EXT      = 1'b1
   } cii_mode_t;

   // apb request side, driven by the bus master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } cii_apb_req_t;

   // apb answer side, driven by this slave
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } cii_apb_rsp_t;
endpackage
`default_nettype wire

// ---- logic/cii_prio_enc.sv ----
// fixed priority encoder for individual hardware requests
`timescale 1ns/100ps
`default_nettype none
module cii_prio_enc #(
   parameter int N = 6                        // number of request lines
) (
   input  wire logic [N-1:0] req,             // request lines, level
   output logic              any,             // some line requests
   output logic [5:0]        idx              // highest requesting line
);
   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   // the index output is six bits wide and could name 64 lines; the check allows 1 to 63
   if (N < 1 || N > 63) begin : g_bad_n
      $error("cii_prio_enc: N out of range");
   end

   // ----------------------------------------------------------------
   // encoding
   // ----------------------------------------------------------------
   // higher index wins: later loop passes override lower ones
   always_comb begin
      any = 1'b0;
      idx = 6'h00;
      for (int i = 0; i < N; i++) begin
         if (req[i]) begin
            any = 1'b1;
            idx = 6'(i);
         end
      end
   end
endmodule // cii_prio_enc
`default_nettype wire

// ---- logic/cii_core_irq_if.sv ----
// core interrupt interface: request inputs, priority readback, timer merge, apb registers
// ----------------------------------------------------------------
// Notes on behaviour
// - vectored mode: six lines, ranked internally
// - external mode: inputs are 6-bit code, zero idle
// - on take in external mode, capture merged code into requested field
// - priority output mirrors field, updates on pulse
// - 3-bit selector merges timer; 0,1 nowhere
// - taken pulse lasts one clock for each clock that a take is accepted
// ----------------------------------------------------------------
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cii_regs.svh"
module cii_core_irq_if #(
   parameter int NREQ = 6                          // request input count
) (
   input  wire logic                 ref_clk,                // 125 MHz core clock
   input  wire logic                 sys_rst,                // sync reset, high
   input  wire cii_pkg::cii_apb_req_t apb_req,               // apb request
   output cii_pkg::cii_apb_rsp_t     apb_rsp,                // apb answer
   input  wire logic [NREQ-1:0]      irq_req_in,             // request pins
   input  wire logic                 timer_irq_in,           // internal timer level
   input  wire logic [2:0]           timer_irq_merge_select, // static merge selector
   input  wire logic                 exc_take_in,            // core begins interrupt exception
   output logic                      core_irq_pending,       // request for the core
   output logic [5:0]                core_vector_out,        // vector for the core
   output logic [5:0]                current_prio_level_out, // priority to controller
   output logic                      irq_taken_pulse,        // taken, one clock
   output logic                      irq_line                // summary interrupt
);
   import cii_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   // the external code and the register fields are fixed at six lines
   if (NREQ != 6) begin : g_bad_nreq
      $error("cii_core_irq_if: NREQ must be 6");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [NREQ-1:0] sync1_q, sync2_q;        // vectored-mode pin synchroniser
   logic [31:0]     ctrl_q, ctrl_d;          // mode and line enables
   logic [5:0]      ripl_q, ripl_d;          // requested_prio_field
   logic [5:0]      ipl_q, ipl_d;            // prio_level_field
   logic [5:0]      ipl_out_q, ipl_out_d;    // priority output register
   logic            taken_q, taken_d;        // taken pulse register
   logic            pend_q, pend_d;          // pending to core
   logic [5:0]      vec_q, vec_d;            // vector to core
   logic [1:0]      istat_q, istat_d;        // sticky events
   logic [1:0]      imask_q, imask_d;        // event mask
   logic            timer_prev_q;            // timer edge memory
   logic [31:0]     rdata_q, rdata_d;        // registered read data
   logic            err_q, err_d;            // registered slave error

   cii_mode_t       mode;                    // current interrupt mode
   logic [NREQ-1:0] timer_onehot;            // timer routed to one line
   logic [NREQ-1:0] vec_lines;               // vectored lines after merge
   logic [5:0]      ext_code;                // external code after merge
   logic            enc_any;                 // encoder found a line
   logic [5:0]      enc_idx;                 // encoder winner
   logic            take;                    // accepted take request
   logic            wr_en;                   // apb write in access phase
   logic            timer_rise;              // timer event

   assign mode = cii_mode_t'(ctrl_q[`CII_CTRL_MODE_BIT]);

   // ----------------------------------------------------------------
   // timer merge
   // ----------------------------------------------------------------
   // timer merged by selector
   always_comb begin
      timer_onehot = '0;
      for (int i = 0; i < NREQ; i++) begin
         if (timer_irq_merge_select == 3'(i + `CII_SEL_BASE)) begin
            timer_onehot[i] = timer_irq_in;
         end
      end
   end

   // vectored lines use synchronised pins, gated by enables
   assign vec_lines = (sync2_q | timer_onehot) & ctrl_q[`CII_CTRL_EN_LSB +: NREQ];
   assign ext_code  = irq_req_in | timer_onehot;

   cii_prio_enc #(.N(NREQ)) u_enc (
      .req (vec_lines),
      .any (enc_any),
      .idx (enc_idx)
   );

   // ----------------------------------------------------------------
   // request path to the core
   // ----------------------------------------------------------------
   // a take is only honoured while a request is offered
   assign take       = exc_take_in && pend_q;
   assign wr_en      = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign timer_rise = timer_irq_in && !timer_prev_q;

   always_comb begin
      pend_d    = 1'b0;
      vec_d     = 6'h00;
      taken_d   = take;
      ripl_d    = ripl_q;
      ipl_out_d = ipl_out_q;
      if (mode == CII_MODE_EXT) begin
         pend_d = (ext_code != 6'h00);
         vec_d  = ext_code;
         if (take) begin
            ripl_d = ext_code;
         end
      end else begin
         pend_d = enc_any;
         vec_d  = enc_idx;
      end
      // output follows field only with pulse
      if (taken_q) begin
         ipl_out_d = ipl_q;
      end
   end

   // ----------------------------------------------------------------
   // apb registers
   // ----------------------------------------------------------------
   // zero wait states: read data and error are set up in the setup phase
   always_comb begin
      ctrl_d  = ctrl_q;
      ipl_d   = ipl_q;
      imask_d = imask_q;
      istat_d = istat_q;
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      // decode during setup so the answer stands in the access phase
      if (apb_req.psel && !apb_req.penable) begin
         if (apb_req.paddr == `CII_OFS_CTRL) begin
            rdata_d = ctrl_q;
         end else if (apb_req.paddr == `CII_OFS_CAUSE) begin
            rdata_d[`CII_REQUESTED_PRIO_FIELD_LSB +: 6] = ripl_q;
            rdata_d[`CII_PRIO_LEVEL_FIELD_LSB +: 6]  = ipl_q;
            rdata_d[`CII_CAUSE_SEL_LSB +: 3]  = timer_irq_merge_select;
         end else if (apb_req.paddr == `CII_OFS_PEND) begin
            rdata_d[NREQ-1:0]                = sync2_q;
            rdata_d[`CII_PEND_VEC_LSB +: 6]  = vec_q;
            rdata_d[`CII_PEND_ANY_BIT]       = pend_q;
         end else if (apb_req.paddr == `CII_OFS_ISTAT) begin
            rdata_d[1:0] = istat_q;
         end else if (apb_req.paddr == `CII_OFS_IMASK) begin
            rdata_d[1:0] = imask_q;
         end else begin
            // unmapped address: error, data zero
            err_d = 1'b1;
         end
      end
      if (wr_en) begin
         if (apb_req.paddr == `CII_OFS_CTRL) begin
            ctrl_d = apb_req.pwdata & 32'h0000_3F01;
         end else if (apb_req.paddr == `CII_OFS_CAUSE) begin
            ipl_d = apb_req.pwdata[`CII_PRIO_LEVEL_FIELD_LSB +: 6];
         end else if (apb_req.paddr == `CII_OFS_ISTAT) begin
            istat_d = istat_q & ~apb_req.pwdata[1:0];
         end else if (apb_req.paddr == `CII_OFS_IMASK) begin
            imask_d = apb_req.pwdata[1:0];
         end
      end
      // events set after the clear, so a set in the clear cycle wins
      if (taken_q) begin
         istat_d[`CII_EV_TAKEN_BIT] = 1'b1;
      end
      if (timer_rise) begin
         istat_d[`CII_EV_TIMER_BIT] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sync1_q      <= '0;
         sync2_q      <= '0;
         ctrl_q       <= `CII_CTRL_RST;
         ripl_q       <= 6'h00;
         ipl_q        <= 6'h00;
         ipl_out_q    <= 6'h00;
         taken_q      <= 1'b0;
         pend_q       <= 1'b0;
         vec_q        <= 6'h00;
         istat_q      <= 2'h0;
         imask_q      <= `CII_IMASK_RST;
         timer_prev_q <= 1'b0;
         rdata_q      <= 32'h0000_0000;
         err_q        <= 1'b0;
      end else begin
         sync1_q      <= irq_req_in;
         sync2_q      <= sync1_q;
         ctrl_q       <= ctrl_d;
         ripl_q       <= ripl_d;
         ipl_q        <= ipl_d;
         ipl_out_q    <= ipl_out_d;
         taken_q      <= taken_d;
         pend_q       <= pend_d;
         vec_q        <= vec_d;
         istat_q      <= istat_d;
         imask_q      <= imask_d;
         timer_prev_q <= timer_irq_in;
         rdata_q      <= rdata_d;
         err_q        <= err_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign apb_rsp.pready          = 1'b1;
   assign apb_rsp.pslverr         = err_q && apb_req.psel && apb_req.penable;
   assign apb_rsp.prdata          = rdata_q;
   assign core_irq_pending        = pend_q;
   assign core_vector_out         = vec_q;
   assign current_prio_level_out  = ipl_out_q;
   assign irq_taken_pulse         = taken_q;
   assign irq_line                = |(istat_q & imask_q);
endmodule // cii_core_irq_if
`default_nettype wire

// ---- tb/cii_core_irq_if_monitor.sv ----
// checker on the ports of the core interrupt interface
`timescale 1ns/100ps
`default_nettype none
module cii_core_irq_if_monitor #(
   parameter int NREQ = 6                             // request input count
) (
   input wire logic                  ref_clk,
   input wire logic                  sys_rst,
   input wire cii_pkg::cii_apb_req_t apb_req,
   input wire cii_pkg::cii_apb_rsp_t apb_rsp,
   input wire logic [NREQ-1:0]       irq_req_in,
   input wire logic                  timer_irq_in,
   input wire logic [2:0]            timer_irq_merge_select,
   input wire logic                  exc_take_in,
   input wire logic                  core_irq_pending,
   input wire logic [5:0]            core_vector_out,
   input wire logic [5:0]            current_prio_level_out,
   input wire logic                  irq_taken_pulse,
   input wire logic                  irq_line
);
   import cii_pkg::*;
   // ----------------------------------------------------------------
   // properties on the core clock
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire logic take_ok = exc_take_in & core_irq_pending;   // accepted take
   property p_take_pulse; take_ok |=> irq_taken_pulse; endproperty
   property p_pulse_cause; irq_taken_pulse |-> $past(take_ok); endproperty
   property p_pulse_one; irq_taken_pulse && !take_ok |=> !irq_taken_pulse; endproperty
   property p_prio_hold; !irq_taken_pulse |=> $stable(current_prio_level_out); endproperty
   // zero code and no merged timer for four samples clears the request
   property p_idle_none;
      (irq_req_in == '0 && (!timer_irq_in || timer_irq_merge_select < 3'h2)) [*4] |=> !core_irq_pending;
   endproperty
   property p_ready; apb_req.psel |-> apb_rsp.pready; endproperty
   property p_err_phase; apb_rsp.pslverr |-> apb_req.psel && apb_req.penable; endproperty
   property p_err_data; apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0; endproperty
   a_take_pulse: assert property (p_take_pulse) else $error("take without pulse");
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without take");
   a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
   a_prio_hold: assert property (p_prio_hold) else $error("priority moved without pulse");
   a_idle_none: assert property (p_idle_none) else $error("request from idle inputs");
   a_ready: assert property (p_ready) else $error("ready low");
   a_err_phase: assert property (p_err_phase) else $error("error outside access");
   a_err_data: assert property (p_err_data) else $error("error with data");
   c_take: cover property (irq_taken_pulse);
   c_err: cover property (apb_rsp.pslverr);
   c_line: cover property ($rose(irq_line));
endmodule // cii_core_irq_if_monitor
bind cii_core_irq_if cii_core_irq_if_monitor #(.NREQ(NREQ)) u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_req_in(irq_req_in), .timer_irq_in(timer_irq_in),
   .timer_irq_merge_select(timer_irq_merge_select), .exc_take_in(exc_take_in),
   .core_irq_pending(core_irq_pending), .core_vector_out(core_vector_out),
   .current_prio_level_out(current_prio_level_out), .irq_taken_pulse(irq_taken_pulse), .irq_line(irq_line));
`default_nettype wire

// ---- tb/cii_ext_ctrl_model.sv ----
// behavioural outside interrupt controller beside the core
`timescale 1ns/100ps
`default_nettype none
module cii_ext_ctrl_model (
   input  wire logic       ref_clk,           // core clock
   input  wire logic       sys_rst,           // sync reset, high
   input  wire logic       post_stb,          // add one pending vector
   input  wire logic [5:0] post_vec,          // vector to add
   input  wire logic       irq_taken_pulse,   // core took the shown vector
   output var  logic [5:0] irq_req_out        // encoded vector, zero idle
);
   logic [63:0] pend_q;                       // pending vectors
   logic [63:0] pend_d;                       // next pending set
   logic [5:0]  top_d;                        // best pending vector
   always_comb begin
      top_d = 6'h00;
      for (int i = 1; i < 64; i++) if (pend_q[i]) top_d = 6'(i);
      pend_d = pend_q;
      if (irq_taken_pulse) pend_d[irq_req_out] = 1'b0;
      if (post_stb) pend_d[post_vec] = 1'b1;
   end
   always_ff @(posedge ref_clk) begin
      pend_q      <= sys_rst ? 64'h0 : pend_d;
      irq_req_out <= sys_rst ? 6'h00 : top_d;
   end
endmodule // cii_ext_ctrl_model
`default_nettype wire

// ---- tb/test_core_interrupt_interface.sv ----
// testbench of the core interrupt interface
`timescale 1ns/100ps
`default_nettype none
`include "cii_regs.svh"
module test_core_interrupt_interface;
   import cii_pkg::*;
   logic         ref_clk = 1'b0;
   logic         sys_rst = 1'b1;
   cii_apb_req_t apb_req = '0;
   cii_apb_rsp_t apb_rsp;
   wire logic [5:0] irq_req_in;
   logic         timer_irq_in = 1'b0;
   logic [2:0]   timer_irq_merge_select = 3'h2;
   logic         exc_take_in = 1'b0;
   logic         core_irq_pending, irq_taken_pulse, irq_line, er, ok;
   logic [5:0]   core_vector_out, current_prio_level_out;
   logic         post_stb = 1'b0;
   logic [5:0]   post_vec = 6'h00;
   logic [31:0]  rd;
   int           error_cnt = 0;
   int           check_count = 0;
   cii_core_irq_if dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .irq_req_in(irq_req_in), .timer_irq_in(timer_irq_in), .timer_irq_merge_select(timer_irq_merge_select),
      .exc_take_in(exc_take_in), .core_irq_pending(core_irq_pending), .core_vector_out(core_vector_out),
      .current_prio_level_out(current_prio_level_out), .irq_taken_pulse(irq_taken_pulse), .irq_line(irq_line));
   cii_ext_ctrl_model u_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .post_stb(post_stb), .post_vec(post_vec),
      .irq_taken_pulse(irq_taken_pulse), .irq_req_out(irq_req_in));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // apb transfer; request held until the edge that sees pready, answer taken there
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge ref_clk);
         {ok, er, rd} = {apb_rsp.pready, apb_rsp.pslverr, apb_rsp.prdata};
         if (ok === 1'b1) break;
      end
      apb_req <= '0;
      if (n == 16) begin
         error_cnt++;
         stop_test;
      end
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      check(nm, rd, exp);
   endtask
   task wait_pend(input logic exp);
      int n;
      for (n = 0; n < 20 && core_irq_pending !== exp; n++) @(negedge ref_clk);
      check("pending", {31'h0, core_irq_pending}, {31'h0, exp});
      if (n == 20) stop_test;
   endtask
   task post(input logic [5:0] v);
      @(posedge ref_clk);
      post_stb <= 1'b1;
      post_vec <= v;
      @(posedge ref_clk);
      post_stb <= 1'b0;
   endtask
   task take(input logic [5:0] ipl);
      @(posedge ref_clk);
      exc_take_in <= 1'b1;
      @(posedge ref_clk);
      exc_take_in <= 1'b0;
      @(negedge ref_clk);
      check("taken", {31'h0, irq_taken_pulse}, 32'h1);
      @(negedge ref_clk);
      check("taken", {31'h0, irq_taken_pulse}, 32'h0);
      check("prio", {26'h0, current_prio_level_out}, {26'h0, ipl});
   endtask
   // ----------------------------------------------------------------
   // clock and main sequence
   // ----------------------------------------------------------------
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(`CII_OFS_CTRL, `CII_CTRL_RST, "ctrl");
      rd_chk(`CII_OFS_IMASK, 32'h0, "imask");
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      check("slverr", {31'h0, er}, 32'h1);
      post(6'h24);
      wait_pend(1'b1);
      check("vector", {26'h0, core_vector_out}, 32'h5);
      apb(1'b1, `CII_OFS_CTRL, 32'h0000_1F00);
      repeat (4) @(negedge ref_clk);
      check("vector", {26'h0, core_vector_out}, 32'h2);
      for (int s = 0; s < 8; s++) begin
         @(posedge ref_clk);
         sys_rst <= 1'b1;
         timer_irq_merge_select <= 3'(s);
         timer_irq_in <= 1'b1;
         repeat (3) @(posedge ref_clk);
         sys_rst <= 1'b0;
         repeat (5) @(negedge ref_clk);
         check("tmr pend", {31'h0, core_irq_pending}, {31'h0, s > 1});
         if (s > 1) check("tmr vec", {26'h0, core_vector_out}, 32'(s - 2));
      end
      @(posedge ref_clk);
      timer_irq_in <= 1'b0;
      apb(1'b1, `CII_OFS_CTRL, 32'h0000_3F01);
      apb(1'b1, `CII_OFS_CAUSE, 32'h0000_1500);
      post(6'h21);
      post(6'h0A);
      wait_pend(1'b1);
      check("vector", {26'h0, core_vector_out}, 32'h21);
      take(6'h15);
      rd_chk(`CII_OFS_CAUSE, 32'h0007_1521, "cause");
      take(6'h15);
      rd_chk(`CII_OFS_CAUSE, 32'h0007_150A, "cause");
      wait_pend(1'b0);
      // taken event and the timer edge left by the selector sweep are both sticky
      apb(1'b0, `CII_OFS_ISTAT, 32'h0);
      check("istat", rd, 32'h3);
      check("irq", {31'h0, irq_line}, 32'h0);
      apb(1'b1, `CII_OFS_IMASK, 32'h1);
      repeat (2) @(negedge ref_clk);
      check("irq", {31'h0, irq_line}, 32'h1);
      apb(1'b1, `CII_OFS_ISTAT, 32'h1);
      repeat (2) @(negedge ref_clk);
      check("irq", {31'h0, irq_line}, 32'h0);
      stop_test;
   end
endmodule // test_core_interrupt_interface
`default_nettype wire
